// >>> hdl/ctp_pkg.sv
`default_nettype none
package ctp_pkg;
   // timers: 0/1 first pair, 2/3 second pair; even = low word
   localparam int NUM_TIMERS = 4;
   localparam int NUM_PAIRS  = 2;

   // control word bit positions
   localparam int BIT_COUNT_RUN      = 15;
   localparam int BIT_HALT_IN_IDLE   = 13;
   localparam int BIT_EXT_SRC_HI     = 9;
   localparam int BIT_EXT_SRC_LO     = 8;
   localparam int BIT_GATED_ACCUM    = 6;
   localparam int BIT_PRESCALE_HI    = 5;
   localparam int BIT_PRESCALE_LO    = 4;
   localparam int BIT_CASCADE_SELECT = 3;
   localparam int BIT_CLOCK_SOURCE   = 1;

   // writable bits; odd timers have no cascade bit
   localparam logic [15:0] CTRL_MASK_EVEN = 16'hA37A;
   localparam logic [15:0] CTRL_MASK_ODD  = 16'hA372;
   localparam logic [15:0] CTRL_RESET     = 16'h0000;
   localparam logic [15:0] COUNT_RESET    = 16'h0000;
   localparam logic [15:0] PERIOD_RESET   = 16'hFFFF;

   // external source field encodings
   localparam logic [1:0] SRC_GENERIC_EXT = 2'b11;
   localparam logic [1:0] SRC_LOWP_OSC    = 2'b10;
   localparam logic [1:0] SRC_CLOCK_PIN   = 2'b01;
   localparam logic [1:0] SRC_SECOND_OSC  = 2'b00;

   // prescale terminal counts for 1:1, 1:8, 1:64, 1:256
   localparam logic [7:0] PSC_LAST_1   = 8'h00;
   localparam logic [7:0] PSC_LAST_8   = 8'h07;
   localparam logic [7:0] PSC_LAST_64  = 8'h3F;
   localparam logic [7:0] PSC_LAST_256 = 8'hFF;
   localparam logic [7:0] PSC_RESET    = 8'h00;

   // register map, byte addresses, one word per register
   localparam logic [7:0] OFS_CTRL_BASE   = 8'h00;
   localparam logic [7:0] OFS_COUNT_BASE  = 8'h10;
   localparam logic [7:0] OFS_PERIOD_BASE = 8'h20;
   localparam logic [1:0] GRP_CTRL   = 2'b00;
   localparam logic [1:0] GRP_COUNT  = 2'b01;
   localparam logic [1:0] GRP_PERIOD = 2'b10;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0]
   {
      SRC_SEL_SECO = 2'b00,
      SRC_SEL_PIN  = 2'b01,
      SRC_SEL_LOWP = 2'b10,
      SRC_SEL_GEN  = 2'b11
   } ctp_src_t;
endpackage : ctp_pkg
`default_nettype wire

// >>> hdl/ctp_tick_if.sv
`default_nettype none
interface ctp_tick_if;
   logic [15:0] ctrl;
   logic        ctlWrite;
   logic        idle;
   logic [2:0]  sharedEdge;
   logic        pinEdge;
   logic        pinLevel;
   logic        tick;

   modport ctl
   (
      output ctrl, ctlWrite, idle, sharedEdge, pinEdge, pinLevel,
      input  tick
   );
   modport unit
   (
      input  ctrl, ctlWrite, idle, sharedEdge, pinEdge, pinLevel,
      output tick
   );
endinterface : ctp_tick_if
`default_nettype wire

// >>> hdl/ctp_prescaler.sv
`default_nettype none
module ctp_prescaler
   import ctp_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // control and tick
   ctp_tick_if.unit  tif
);
   logic [7:0] pscR;
   logic [7:0] pscLast;
   logic       srcTick;
   logic       running;

   ////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      case (tif.ctrl[BIT_PRESCALE_HI:BIT_PRESCALE_LO])
         2'b11:   pscLast = PSC_LAST_256;
         2'b10:   pscLast = PSC_LAST_64;
         2'b01:   pscLast = PSC_LAST_8;
         default: pscLast = PSC_LAST_1;
      endcase
   end

   always_comb
   begin
      if (tif.ctrl[BIT_CLOCK_SOURCE])
      begin
         // gate ignored on external source
         case (ctp_src_t'(tif.ctrl[BIT_EXT_SRC_HI:BIT_EXT_SRC_LO]))
            SRC_SEL_GEN:  srcTick = tif.sharedEdge[0];
            SRC_SEL_LOWP: srcTick = tif.sharedEdge[1];
            SRC_SEL_PIN:  srcTick = tif.pinEdge;
            SRC_SEL_SECO: srcTick = tif.sharedEdge[2];
            default:      srcTick = 1'b0;
         endcase
      end
      else if (tif.ctrl[BIT_GATED_ACCUM])
         srcTick = tif.pinLevel;
      else
         srcTick = 1'b1;
   end

   assign running = tif.ctrl[BIT_COUNT_RUN] & ~(tif.ctrl[BIT_HALT_IN_IDLE] & tif.idle);

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         pscR <= PSC_RESET;
      else if (tif.ctlWrite && tif.ctrl[BIT_COUNT_RUN])
         pscR <= PSC_RESET;
      else if (running && srcTick)
      begin
         if (pscR >= pscLast)
            pscR <= PSC_RESET;
         else
            pscR <= pscR + 8'h01;
      end
   end

   // internal clock runs at the bus clock rate, one source tick per edge
   assign tif.tick = running & srcTick & (pscR >= pscLast);
endmodule : ctp_prescaler
`default_nettype wire

// >>> hdl/ctp_top.sv
`default_nettype none
// Notes on behaviour
// - mode bit 1 joins a pair into one 32-bit timer, 0 keeps two 16-bit.
// - cascaded: even timer is low word, odd is high word, both readable live.
// - cascaded: odd control ignored; even control and pins run the pair.
// - cascaded: period match is reported on the odd timer's flag.
// - cascaded period: odd period is high word, even period low word.
// - cascaded: interrupt when full 32-bit count equals 32-bit period.
// - converter trigger only from first pair: 32-bit match or odd timer match.
// - timer and synchronous counter modes only; no asynchronous counting.
// - on bit starts and stops counting; governs whole pair when cascaded.
// - halt-in-idle bit stops counting while chip idles, else keeps counting.
// - source field: 11 generic, 10 low-power osc, 01 own pin, 00 secondary.
// - clock-source bit 1 uses selected source, 0 uses internal clock.
// - gate bit gates internal clock by pin; ignored on external source.
// - prescale field: 11 1:256, 10 1:64, 01 1:8, 00 1:1.
// - control write while running resets prescaler; software avoids it.
// - second pair has its own cascade bit at the same position.
module ctp_top
   import ctp_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // clock sources and gate pins, asynchronous
   input  wire logic        genericExtTimerInput,
   input  wire logic        lowPowerInternalOsc,
   input  wire logic        secondaryOsc,
   input  wire logic [3:0]  timerClockPin,
   // chip state
   input  wire logic        idleMode,
   // events
   output logic [3:0]       periodMatchIrq,
   output logic             adcTrigger
);
   logic [15:0] ctrlR   [NUM_TIMERS];
   logic [15:0] cntR    [NUM_TIMERS];
   logic [15:0] perR    [NUM_TIMERS];
   logic [15:0] cntNxt  [NUM_TIMERS];
   logic [3:0]  irqNxt;
   logic [3:0]  tickVec;
   logic [3:0]  ctlWriteVec;
   logic        adcNxt;

   logic [6:0]  syncAR;
   logic [6:0]  syncBR;
   logic [6:0]  syncCR;
   logic [6:0]  edgeVec;

   logic [7:0]  awAddrR;
   logic        awHeldR;
   logic [31:0] wDataR;
   logic [3:0]  wStrbR;
   logic        wHeldR;
   logic        bValidR;
   logic [1:0]  bRespR;
   logic        rValidR;
   logic [31:0] rDataR;
   logic [1:0]  rRespR;
   logic        doWrite;
   logic        wrMapped;
   logic [1:0]  wrGroup;
   logic [1:0]  wrIdx;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; only the second stage and later are looked at

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         syncAR <= 7'h00;
         syncBR <= 7'h00;
         syncCR <= 7'h00;
      end
      else
      begin
         syncAR <= {timerClockPin, secondaryOsc, lowPowerInternalOsc, genericExtTimerInput};
         syncBR <= syncAR;
         syncCR <= syncBR;
      end
   end

   // rising edges counted synchronously, never on the pin itself
   assign edgeVec = syncBR & ~syncCR;

   ////////////////////////////////////////////////////////////////////////////
   // one prescaler and source selector per timer

   for (genvar i = 0; i < NUM_TIMERS; i++)
   begin : g_unit
      ctp_tick_if tif ();
      assign tif.ctrl       = ctrlR[i];
      assign tif.ctlWrite   = ctlWriteVec[i];
      assign tif.idle       = idleMode;
      assign tif.sharedEdge = edgeVec[2:0];
      assign tif.pinEdge    = edgeVec[3 + i];
      assign tif.pinLevel   = syncBR[3 + i];
      assign tickVec[i]     = tif.tick;

      ctp_prescaler u_psc
      (
         .clk   (clk),
         .reset (reset),
         .tif   (tif)
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // write decode

   assign doWrite  = awHeldR & wHeldR & ~bValidR;
   assign wrGroup  = awAddrR[5:4];
   assign wrIdx    = awAddrR[3:2];
   assign wrMapped = (awAddrR[7:6] == 2'b00) && (awAddrR[1:0] == 2'b00)
                     && (wrGroup != 2'b11);

   always_comb
   begin
      for (int i = 0; i < NUM_TIMERS; i++)
         ctlWriteVec[i] = doWrite && wrMapped && (wrGroup == GRP_CTRL)
                          && (wrIdx == 2'(i));
   end

   function automatic logic [15:0] ctpMerge(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb,
                                            input logic [15:0] mask);
      logic [15:0] res;
      res = old;
      if (strb[0])
         res[7:0] = data[7:0];
      if (strb[1])
         res[15:8] = data[15:8];
      ctpMerge = (res & mask) | (old & ~mask);
   endfunction : ctpMerge

   ////////////////////////////////////////////////////////////////////////////
   // counting; a software count write wins over a tick in the same cycle

   always_comb
   begin
      for (int i = 0; i < NUM_TIMERS; i++)
         cntNxt[i] = cntR[i];
      irqNxt = 4'h0;
      for (int p = 0; p < NUM_PAIRS; p++)
      begin
         if (ctrlR[2*p][BIT_CASCADE_SELECT])
         begin
            // odd unit's tick unused, its control has no say
            if (tickVec[2*p])
            begin
               if ({cntR[2*p+1], cntR[2*p]} == {perR[2*p+1], perR[2*p]})
               begin
                  cntNxt[2*p]   = COUNT_RESET;
                  cntNxt[2*p+1] = COUNT_RESET;
                  irqNxt[2*p+1] = 1'b1;
               end
               else
                  {cntNxt[2*p+1], cntNxt[2*p]} =
                     {cntR[2*p+1], cntR[2*p]} + 32'h0000_0001;
            end
         end
         else
         begin
            for (int j = 2*p; j < 2*p + 2; j++)
            begin
               if (tickVec[j])
               begin
                  if (cntR[j] == perR[j])
                  begin
                     cntNxt[j] = COUNT_RESET;
                     irqNxt[j] = 1'b1;
                  end
                  else
                     cntNxt[j] = cntR[j] + 16'h0001;
               end
            end
         end
      end
      for (int i = 0; i < NUM_TIMERS; i++)
         if (doWrite && wrMapped && (wrGroup == GRP_COUNT) && (wrIdx == 2'(i)))
            cntNxt[i] = ctpMerge(cntR[i], wDataR, wStrbR, 16'hFFFF);
   end

   // first pair only; either form ends in the odd timer's flag
   assign adcNxt = irqNxt[1];

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < NUM_TIMERS; i++)
            cntR[i] <= COUNT_RESET;
         periodMatchIrq <= 4'h0;
         adcTrigger     <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < NUM_TIMERS; i++)
            cntR[i] <= cntNxt[i];
         periodMatchIrq <= irqNxt;
         adcTrigger     <= adcNxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control and period registers

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < NUM_TIMERS; i++)
         begin
            ctrlR[i] <= CTRL_RESET;
            perR[i]  <= PERIOD_RESET;
         end
      end
      else if (doWrite && wrMapped)
      begin
         for (int i = 0; i < NUM_TIMERS; i++)
         begin
            if (wrIdx == 2'(i) && wrGroup == GRP_CTRL)
               ctrlR[i] <= ctpMerge(ctrlR[i], wDataR, wStrbR,
                                    (i % 2 == 0) ? CTRL_MASK_EVEN : CTRL_MASK_ODD);
            if (wrIdx == 2'(i) && wrGroup == GRP_PERIOD)
               perR[i] <= ctpMerge(perR[i], wDataR, wStrbR, 16'hFFFF);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channels; address and data taken in either order

   assign s_axi_awready = ~awHeldR & ~bValidR;
   assign s_axi_wready  = ~wHeldR & ~bValidR;
   assign s_axi_bvalid  = bValidR;
   assign s_axi_bresp   = bRespR;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         awAddrR <= 8'h00;
         awHeldR <= 1'b0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         awAddrR <= s_axi_awaddr;
         awHeldR <= 1'b1;
      end
      else if (doWrite)
         awHeldR <= 1'b0;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wDataR <= 32'h0000_0000;
         wStrbR <= 4'h0;
         wHeldR <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         wDataR <= s_axi_wdata;
         wStrbR <= s_axi_wstrb;
         wHeldR <= 1'b1;
      end
      else if (doWrite)
         wHeldR <= 1'b0;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         bValidR <= 1'b0;
         bRespR  <= RESP_OKAY;
      end
      else if (doWrite)
      begin
         bValidR <= 1'b1;
         bRespR  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bValidR <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read; counts read live so the pair can be watched running

   assign s_axi_arready = ~rValidR;
   assign s_axi_rvalid  = rValidR;
   assign s_axi_rdata   = rDataR;
   assign s_axi_rresp   = rRespR;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rValidR <= 1'b0;
         rDataR  <= 32'h0000_0000;
         rRespR  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rValidR <= 1'b1;
         rRespR  <= RESP_OKAY;
         rDataR  <= 32'h0000_0000;
         if (s_axi_araddr[7:6] != 2'b00 || s_axi_araddr[1:0] != 2'b00)
            rRespR <= RESP_SLVERR;
         else
         begin
            case (s_axi_araddr[5:4])
               GRP_CTRL:   rDataR <= {16'h0000, ctrlR[s_axi_araddr[3:2]]};
               GRP_COUNT:  rDataR <= {16'h0000, cntR[s_axi_araddr[3:2]]};
               GRP_PERIOD: rDataR <= {16'h0000, perR[s_axi_araddr[3:2]]};
               default:    rRespR <= RESP_SLVERR;
            endcase
         end
      end
      else if (s_axi_rready)
         rValidR <= 1'b0;
   end
endmodule : ctp_top
`default_nettype wire

// >>> bench/ctp_chk.sv
`default_nettype none
module ctp_chk
(
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // register bus
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // events
   input wire logic [3:0]  periodMatchIrq,
   input wire logic        adcTrigger
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   property p_trig; adcTrigger == periodMatchIrq[1]; endproperty
   a_trig: assert property (p_trig)
      else $error("trigger differs from first odd timer match");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold)
      else $error("write response dropped early");
   property p_noaw; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_noaw: assert property (p_noaw)
      else $error("write accepted while response pending");
   property p_rafter; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rafter: assert property (p_rafter)
      else $error("read data late");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold)
      else $error("read data dropped early");
   property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid [*2]; endproperty
   a_rdrop: assert property (p_rdrop)
      else $error("read data repeated");
   // unmapped places answer with an error and zero data
   property p_unmap; s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h30
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000; endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not refused");
   property p_hi0; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
   a_hi0: assert property (p_hi0)
      else $error("upper read half not zero");
endmodule : ctp_chk
bind ctp_top ctp_chk u_chk
(
   .clk(clk), .reset(reset), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .periodMatchIrq(periodMatchIrq), .adcTrigger(adcTrigger)
);
`default_nettype wire

// >>> bench/cascadable_timer_pair_tb_top.sv
`default_nettype none
module cascadable_timer_pair_tb_top import ctp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV[4] = '{1, 8, 64, 256};
   ////////////////////////////////////////////////////////////////////////////////
   logic        clk, reset, idleMode, adcTrigger;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        genericExtTimerInput, lowPowerInternalOsc, secondaryOsc;
   logic [3:0]  timerClockPin, periodMatchIrq;
   int          nEv[5], snapV[5], dlt[5];
   int          nErrors, numChecks;

   ctp_top DUT
   (
      .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .genericExtTimerInput(genericExtTimerInput), .lowPowerInternalOsc(lowPowerInternalOsc),
      .secondaryOsc(secondaryOsc), .timerClockPin(timerClockPin), .idleMode(idleMode),
      .periodMatchIrq(periodMatchIrq), .adcTrigger(adcTrigger)
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // counted mid-cycle, away from the launching edge
   always @(negedge clk)
   begin
      for (int i = 0; i < 4; i++)
         nEv[i] += (periodMatchIrq[i] === 1'b1);
      nEv[4] += (adcTrigger === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d errors %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp)
      begin
         nErrors++;
         $display("Error %0t: value %h expected %h", $time, got, exp);
      end
   endtask : chkv

   task automatic chkr(input int got, input int lo, input int hi);
      numChecks++;
      if (got < lo || got > hi)
      begin
         nErrors++;
         $display("Error %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask : chkr

   task automatic hang();
      nErrors++;
      $display("Error %0t: bus wait ran out", $time);
      summarize();
   endtask : hang

   function automatic logic [7:0] ad(input logic [7:0] base, input int i);
      return base + 8'(4 * i);
   endfunction : ad
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
            break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 50)
         hang();
   endtask : wr

   task automatic w(input logic [7:0] a, input logic [15:0] d);
      logic [1:0] r;
      wr(a, d, r);
   endtask : w

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 50)
         hang();
   endtask : rd

   task automatic span(input int cyc);
      snapV = nEv;
      repeat (cyc) @(posedge clk);
      foreach (dlt[i]) dlt[i] = nEv[i] - snapV[i];
   endtask : span

   task automatic drv(input int code, input logic v);
      case (code)
         0: secondaryOsc <= v;
         1: timerClockPin[0] <= v;
         2: lowPowerInternalOsc <= v;
         default: genericExtTimerInput <= v;
      endcase
   endtask : drv
   ////////////////////////////////////////////////////////////////////////////////
   task automatic regScn();
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 4; i++)
      begin
         rd(ad(OFS_CTRL_BASE, i), d, r);
         chkv(d, 32'(CTRL_RESET));
         rd(ad(OFS_COUNT_BASE, i), d, r);
         chkv(d, 32'(COUNT_RESET));
         rd(ad(OFS_PERIOD_BASE, i), d, r);
         chkv(d, 32'(PERIOD_RESET));
         wr(ad(OFS_CTRL_BASE, i), 16'h7FFF, r);
         chkv(32'(r), 32'(RESP_OKAY));
         rd(ad(OFS_CTRL_BASE, i), d, r);
         chkv(d, 32'(16'h7FFF & (i[0] ? CTRL_MASK_ODD : CTRL_MASK_EVEN)));
         w(ad(OFS_CTRL_BASE, i), 16'h0000);
      end
      rd(8'h30, d, r);
      chkv({d[31:2], r}, 32'(RESP_SLVERR));
      wr(8'h40, 16'h1234, r);
      chkv(32'(r), 32'(RESP_SLVERR));
   endtask : regScn

   task automatic prescScn();
      w(ad(OFS_PERIOD_BASE, 0), 16'h0000);
      for (int k = 0; k < 4; k++)
      begin
         w(OFS_CTRL_BASE, 16'h8000 | 16'(k << 4));
         span(1024);
         chkr(dlt[0], 1024 / DIV[k] - 1, 1024 / DIV[k] + 1);
      end
      // each rewrite while running restarts the 1:8 divider
      w(OFS_CTRL_BASE, 16'h8010);
      snapV = nEv;
      repeat (10) w(OFS_CTRL_BASE, 16'h8010);
      chkr(nEv[0] - snapV[0], 0, 0);
      w(OFS_CTRL_BASE, 16'h0000);
      span(40);
      chkr(dlt[0], 0, 0);
   endtask : prescScn

   task automatic idleScn();
      idleMode <= 1'b1;
      w(OFS_CTRL_BASE, 16'hA000);
      span(40);
      chkr(dlt[0], 0, 0);
      w(OFS_CTRL_BASE, 16'h8000);
      span(40);
      chkr(dlt[0], 39, 41);
      idleMode <= 1'b0;
      w(OFS_CTRL_BASE, 16'h0000);
   endtask : idleScn

   task automatic gateScn();
      w(OFS_CTRL_BASE, 16'h8040);
      span(40);
      chkr(dlt[0], 0, 0);
      timerClockPin[0] <= 1'b1;
      repeat (5) @(posedge clk);
      span(40);
      chkr(dlt[0], 39, 41);
      w(OFS_CTRL_BASE, 16'h8142);
      span(40);
      chkr(dlt[0], 0, 1);
      timerClockPin[0] <= 1'b0;
   endtask : gateScn

   task automatic srcScn();
      w(ad(OFS_PERIOD_BASE, 0), 16'h0001);
      for (int c = 0; c < 4; c++)
      begin
         w(OFS_CTRL_BASE, 16'h8002 | 16'(c << 8));
         for (int s = 0; s < 2; s++)
         begin
            snapV = nEv;
            repeat (8)
            begin
               drv((c + s) % 4, 1'b1);
               repeat (4) @(posedge clk);
               drv((c + s) % 4, 1'b0);
               repeat (4) @(posedge clk);
            end
            chkr(nEv[0] - snapV[0], s ? 0 : 3, s ? 0 : 5);
         end
      end
      w(OFS_CTRL_BASE, 16'h0000);
   endtask : srcScn

   task automatic trigScn();
      w(ad(OFS_PERIOD_BASE, 2), 16'h0002);
      w(ad(OFS_PERIOD_BASE, 3), 16'h0002);
      w(ad(OFS_CTRL_BASE, 2), 16'h8000);
      w(ad(OFS_CTRL_BASE, 3), 16'h8000);
      span(30);
      chkr(dlt[2], 9, 11);
      chkr(dlt[3], 9, 11);
      chkr(dlt[4], 0, 0);
      w(ad(OFS_PERIOD_BASE, 1), 16'h0000);
      w(ad(OFS_CTRL_BASE, 1), 16'h8000);
      span(30);
      chkr(dlt[1], 29, 31);
      chkr(dlt[4], dlt[1], dlt[1]);
      w(ad(OFS_CTRL_BASE, 1), 16'h0000);
      w(ad(OFS_CTRL_BASE, 3), 16'h0000);
      w(ad(OFS_CTRL_BASE, 2), 16'h0000);
   endtask : trigScn

   task automatic cascScn(input int p);
      logic [31:0] d;
      logic [1:0]  r;
      int          b;
      b = 2 * p;
      // mode, odd control, periods, counts, then run
      w(ad(OFS_CTRL_BASE, b), 16'h0008);
      w(ad(OFS_CTRL_BASE, b + 1), 16'h8000);
      w(ad(OFS_PERIOD_BASE, b), 16'h0004);
      w(ad(OFS_PERIOD_BASE, b + 1), 16'h0001);
      w(ad(OFS_COUNT_BASE, b), 16'hFFFE);
      w(ad(OFS_COUNT_BASE, b + 1), 16'h0000);
      w(ad(OFS_CTRL_BASE, b), 16'h8008);
      span(40);
      chkr(dlt[b + 1], 1, 1);
      chkr(dlt[b], 0, 0);
      chkr(dlt[4], p == 0, p == 0);
      w(ad(OFS_CTRL_BASE, b), 16'h0008);
      rd(ad(OFS_COUNT_BASE, b + 1), d, r);
      chkv(d, 32'h0000_0000);
      w(ad(OFS_CTRL_BASE, b + 1), 16'h0000);
      w(ad(OFS_CTRL_BASE, b), 16'h0000);
   endtask : cascScn
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      reset = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {genericExtTimerInput, lowPowerInternalOsc, secondaryOsc, idleMode} = '0;
      timerClockPin = 4'h0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      regScn();
      prescScn();
      idleScn();
      gateScn();
      srcScn();
      trigScn();
      cascScn(0);
      cascScn(1);
      summarize();
   end
endmodule : cascadable_timer_pair_tb_top
`default_nettype wire
